/* File: shared/msr_pkg.sv */
// Purpose: Constants and carrier types for the interrupt message and subsystem registers.
// Assumes: Avalon-MM slave with 32-bit data and byte addressing of aligned words.
// Notes:   Overview list below is kept short; details live in the modules.
package msr_pkg;

   // Register byte offsets.
   localparam logic [7:0] MSR_OFF_CAP_CONTROL = 8'hD0;
   localparam logic [7:0] MSR_OFF_ADDR_LOW    = 8'hD4;
   localparam logic [7:0] MSR_OFF_ADDR_HIGH   = 8'hD8;
   localparam logic [7:0] MSR_OFF_MSG_DATA    = 8'hDC;
   localparam logic [7:0] MSR_OFF_SUB_HEADER  = 8'hF0;
   localparam logic [7:0] MSR_OFF_SUB_IDENT   = 8'hF4;

   // Field positions within the capability control word.
   localparam int MSR_POS_NEXT_LINK  = 8;
   localparam int MSR_POS_ENABLE     = 16;
   localparam int MSR_POS_MM_CAPABLE = 17;
   localparam int MSR_POS_MM_GRANTED = 20;
   localparam int MSR_POS_WIDE_ADDR  = 23;

   // Fixed and reset values.
   localparam logic [7:0]  MSR_CAPABILITY_IDENTIFIER_MSI      = 8'h05;
   localparam logic [7:0]  MSR_CAPABILITY_IDENTIFIER_SUBSYS   = 8'h0D;
   localparam logic [7:0]  MSR_RST_NEXT_LINK  = 8'h00;
   localparam logic [2:0]  MSR_MM_CAPABLE_VAL = 3'h0;
   localparam logic [2:0]  MSR_MM_GRANTED_VAL = 3'h0;
   localparam logic        MSR_WIDE_ADDR_VAL  = 1'b1;
   localparam logic [31:0] MSR_RST_WORD       = 32'h0000_0000;
   localparam logic [15:0] MSR_RST_HALF       = 16'h0000;
   localparam logic [31:0] MSR_UNMAPPED_READ  = 32'h0000_0000;

   // Message write request toward the upstream port.
   typedef struct packed {
      logic        valid;    // Request pending.
      logic        wide;     // Use a 64-bit address.
      logic [63:0] addr;     // Doubleword-aligned target address.
      logic [31:0] data;     // Payload word.
   } msr_msg_t;

   // Programmable register contents.
   typedef struct packed {
      logic        enable;        // Message generation enable.
      logic [7:0]  msi_next;      // Loadable next link of interrupt header.
      logic [29:0] addr_low;      // Address bits 31:2.
      logic [31:0] addr_high;     // Upper address.
      logic [15:0] payload;       // Message payload.
      logic [7:0]  sub_next;      // Loadable next link of subsystem header.
      logic [15:0] vendor_code;   // Subsystem vendor code.
      logic [15:0] sub_code;      // Subsystem code.
   } msr_regs_t;

endpackage : msr_pkg

/* File: hw/msr_msg_gen.sv */
// Purpose: Builds one interrupt message write from the programmed registers.
// Assumes: Trigger is a one-cycle pulse from logic on the same clock.
// Notes:   A trigger while a request is still pending is merged into it.
`timescale 1ns/1ns

module msr_msg_gen
   import msr_pkg::*;
(
   input  wire logic      clk_i,     // Device clock.
   input  wire logic      rst_i,     // Synchronous reset, active high.
   input  wire msr_regs_t regs_i,    // Current register contents.
   input  wire logic      trig_i,    // Interrupt event pulse.
   input  wire logic      ack_i,     // Upstream accepted the request.
   output msr_msg_t       msg_o      // Registered request.
);

   // All state of the generator.
   typedef struct packed {
      msr_msg_t msg;   // Pending request.
   } msr_gen_state_t;

   msr_gen_state_t st_q;   // Registered state.
   msr_gen_state_t st_d;   // Next state.

   // Next-state logic for the request.
   always_comb begin
      st_d = st_q;
      if (st_q.msg.valid && ack_i) begin
         st_d.msg.valid = 1'b0;
      end
      // Events are dropped while disabled so no stale write leaks out later.
      if (trig_i && regs_i.enable) begin
         st_d.msg.valid = 1'b1;
         st_d.msg.wide  = (regs_i.addr_high != 32'h0000_0000);
         // A zero upper half leaves only the 32-bit lower address.
         st_d.msg.addr  = {regs_i.addr_high, regs_i.addr_low, 2'h0};
         st_d.msg.data  = {16'h0000, regs_i.payload};
      end
      // Withdrawing enable cancels an unaccepted request.
      if (!regs_i.enable) begin
         st_d.msg.valid = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign msg_o = st_q.msg;

endmodule // msr_msg_gen

/* File: hw/msr_regs.sv */
// Purpose: Interrupt message capability and subsystem identity registers.
// Assumes: Avalon-MM slave; each access answers one cycle after it is seen.
// Notes:   Generated message writes leave on the MSG_* ports.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns

module msr_regs
   import msr_pkg::*;
(
   input  wire logic        CLK_I,              // Device clock, 125 MHz.
   input  wire logic        RST_I,              // Synchronous reset, active high.
   input  wire logic [7:0]  AVS_ADDRESS_I,      // Byte address.
   input  wire logic        AVS_READ_I,         // Read request.
   input  wire logic        AVS_WRITE_I,        // Write request.
   input  wire logic [31:0] AVS_WRITEDATA_I,    // Write data.
   input  wire logic [3:0]  AVS_BYTEENABLE_I,   // Byte enables.
   output logic [31:0]      AVS_READDATA_O,     // Read data.
   output logic             AVS_WAITREQUEST_O,  // Stall while high.
   input  wire logic        IRQ_EVENT_I,        // Interrupt event pulse.
   input  wire logic        MSG_ACK_I,          // Upstream took the request.
   output logic             MSG_VALID_O,        // Message write pending.
   output logic             MSG_WIDE_O,         // 64-bit address in use.
   output logic [63:0]      MSG_ADDR_O,         // Message address.
   output logic [31:0]      MSG_DATA_O,         // Message payload.
   output logic             MSI_ENABLE_O        // Enable bit state.
);

   // All state of the register block.
   typedef struct packed {
      msr_regs_t   regs;     // Programmable contents.
      logic        ack;      // Answer cycle of the bus.
      logic [31:0] rdata;    // Registered read data.
      logic        enable;   // Copy of enable for the output.
   } msr_top_state_t;

   msr_top_state_t st_q;   // Registered state.
   msr_top_state_t st_d;   // Next state.
   msr_msg_t       msg;    // Generator output, already registered.

   // Merge write data into a word under the byte enables.
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Read view of the capability control word.
   function automatic logic [31:0] cap_word(input msr_regs_t r);
      logic [31:0] w;
      w = 32'h0000_0000;   // Reserved bits 31:24 read zero.
      w[7:0] = MSR_CAPABILITY_IDENTIFIER_MSI;
      w[MSR_POS_NEXT_LINK +: 8] = r.msi_next;
      w[MSR_POS_ENABLE] = r.enable;
      w[MSR_POS_MM_CAPABLE +: 3] = MSR_MM_CAPABLE_VAL;
      w[MSR_POS_MM_GRANTED +: 3] = MSR_MM_GRANTED_VAL;
      w[MSR_POS_WIDE_ADDR] = MSR_WIDE_ADDR_VAL;
      return w;
   endfunction

   logic        req;     // Access is being presented.
   logic [31:0] rd_mux;  // Read data for the current address.
   logic [31:0] wmerge;  // Merged write value for the current address.

   // Bus decode, read mux and register update.
   always_comb begin
      st_d   = st_q;
      req    = (AVS_READ_I || AVS_WRITE_I) && !st_q.ack;
      rd_mux = MSR_UNMAPPED_READ;
      wmerge = 32'h0000_0000;
      st_d.ack = req;
      // Address decode; unmapped offsets read zero and ignore writes.
      if (AVS_ADDRESS_I == MSR_OFF_CAP_CONTROL) begin
         rd_mux = cap_word(st_q.regs);
      end else if (AVS_ADDRESS_I == MSR_OFF_ADDR_LOW) begin
         rd_mux = {st_q.regs.addr_low, 2'h0};
      end else if (AVS_ADDRESS_I == MSR_OFF_ADDR_HIGH) begin
         rd_mux = st_q.regs.addr_high;
      end else if (AVS_ADDRESS_I == MSR_OFF_MSG_DATA) begin
         rd_mux = {16'h0000, st_q.regs.payload};
      end else if (AVS_ADDRESS_I == MSR_OFF_SUB_HEADER) begin
         rd_mux = {16'h0000, st_q.regs.sub_next, MSR_CAPABILITY_IDENTIFIER_SUBSYS};
      end else if (AVS_ADDRESS_I == MSR_OFF_SUB_IDENT) begin
         rd_mux = {st_q.regs.sub_code, st_q.regs.vendor_code};
      end
      wmerge = merge(rd_mux, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      if (req && AVS_READ_I) begin
         st_d.rdata = rd_mux;
      end
      // Writes land in the request cycle; the answer follows one cycle later.
      if (req && AVS_WRITE_I) begin
         if (AVS_ADDRESS_I == MSR_OFF_CAP_CONTROL) begin
            st_d.regs.msi_next = wmerge[MSR_POS_NEXT_LINK +: 8];
            st_d.regs.enable   = wmerge[MSR_POS_ENABLE];
            // Granted field write is discarded: one message only.
         end else if (AVS_ADDRESS_I == MSR_OFF_ADDR_LOW) begin
            st_d.regs.addr_low = wmerge[31:2];
         end else if (AVS_ADDRESS_I == MSR_OFF_ADDR_HIGH) begin
            st_d.regs.addr_high = wmerge;
         end else if (AVS_ADDRESS_I == MSR_OFF_MSG_DATA) begin
            st_d.regs.payload = wmerge[15:0];
         end else if (AVS_ADDRESS_I == MSR_OFF_SUB_HEADER) begin
            st_d.regs.sub_next = wmerge[15:8];
         end else if (AVS_ADDRESS_I == MSR_OFF_SUB_IDENT) begin
            st_d.regs.vendor_code = wmerge[15:0];
            st_d.regs.sub_code    = wmerge[31:16];
         end
      end
      st_d.enable = st_d.regs.enable;
   end

   // State register; everything clears on reset.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Message write builder.
   msr_msg_gen u_gen (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .regs_i (st_q.regs),
      .trig_i (IRQ_EVENT_I),
      .ack_i  (MSG_ACK_I),
      .msg_o  (msg)
   );

   // Outputs come straight from flip-flops.
   assign AVS_READDATA_O    = st_q.rdata;
   assign AVS_WAITREQUEST_O = !st_q.ack;
   assign MSI_ENABLE_O      = st_q.enable;
   assign MSG_VALID_O       = msg.valid;
   assign MSG_WIDE_O        = msg.wide;
   assign MSG_ADDR_O        = msg.addr;
   assign MSG_DATA_O        = msg.data;

endmodule // msr_regs

/* File: sim/msr_upstream_model.sv */
// Purpose: Upstream port stand-in that accepts message writes.
// Assumes: One clock shared with the register block.
// Notes:   The bench sets the wait so the port acts prompt or slow.
`timescale 1ns/1ns
module msr_upstream_model (
   input  wire logic       clk_i,    // Device clock.
   input  wire logic       rst_i,    // Synchronous reset, active high.
   input  wire logic       valid_i,  // Message write pending.
   input  wire logic [3:0] dly_i,    // Cycles to wait before accepting.
   output logic            ack_o     // Accept pulse, one cycle.
);
   logic [3:0] cnt_q;  // Cycles the current request has waited.
   // The pulse drops once taken, so one accept pairs with one request.
   always_ff @(posedge clk_i) begin
      if (rst_i || !valid_i || ack_o) begin
         ack_o <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         ack_o <= (cnt_q >= dly_i);
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // msr_upstream_model

/* File: sim/msr_regs_sva.sv */
// Purpose: Assertions on the message outputs of the register block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every instance of the register block.
`timescale 1ns/1ns
module msr_regs_sva (
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic        AVS_WRITE_I,
   input wire logic        IRQ_EVENT_I,
   input wire logic        MSG_ACK_I,
   input wire logic        MSG_VALID_O,
   input wire logic        MSG_WIDE_O,
   input wire logic [63:0] MSG_ADDR_O,
   input wire logic [31:0] MSG_DATA_O,
   input wire logic        MSI_ENABLE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   valid_cause_a: assert property ($rose(MSG_VALID_O) |-> $past(IRQ_EVENT_I && MSI_ENABLE_O))
      else $error("Message raised without an enabled event.");
   trig_on_a: assert property (IRQ_EVENT_I && MSI_ENABLE_O && !AVS_WRITE_I && !MSG_ACK_I
      |=> MSG_VALID_O) else $error("Enabled event raised no message.");
   trig_off_a: assert property (IRQ_EVENT_I && !MSI_ENABLE_O && !MSG_VALID_O
      |=> !MSG_VALID_O) else $error("Disabled event raised a message.");
   ack_clear_a: assert property (MSG_VALID_O && MSG_ACK_I && !IRQ_EVENT_I
      |=> !MSG_VALID_O) else $error("Accepted message still pending.");
   msg_hold_a: assert property (MSG_VALID_O && !MSG_ACK_I && !IRQ_EVENT_I && !AVS_WRITE_I
      |=> MSG_VALID_O && $stable(MSG_ADDR_O) && $stable(MSG_DATA_O))
      else $error("Pending message changed or vanished.");
   wide_sel_a: assert property (MSG_VALID_O |-> MSG_WIDE_O == (MSG_ADDR_O[63:32] != 32'h0))
      else $error("Wide flag disagrees with upper address.");
   addr_align_a: assert property (MSG_VALID_O |-> MSG_ADDR_O[1:0] == 2'h0)
      else $error("Message address not doubleword aligned.");
   data_top_a: assert property (MSG_VALID_O |-> MSG_DATA_O[31:16] == 16'h0)
      else $error("Message payload upper half not zero.");
   cover property (MSG_VALID_O && MSG_ACK_I);
   cover property (MSG_VALID_O && MSG_WIDE_O);
   cover property (IRQ_EVENT_I && !MSI_ENABLE_O);
endmodule // msr_regs_sva
bind msr_regs msr_regs_sva u_sva (.CLK_I(CLK_I), .RST_I(RST_I), .AVS_WRITE_I(AVS_WRITE_I),
   .IRQ_EVENT_I(IRQ_EVENT_I), .MSG_ACK_I(MSG_ACK_I), .MSG_VALID_O(MSG_VALID_O),
   .MSG_WIDE_O(MSG_WIDE_O), .MSG_ADDR_O(MSG_ADDR_O), .MSG_DATA_O(MSG_DATA_O),
   .MSI_ENABLE_O(MSI_ENABLE_O));

/* File: sim/testbench.sv */
// Purpose: Register and message tests for the register block.
// Assumes: Design answers each bus access one cycle after taking it.
// Notes:   Bus tasks wait for waitrequest low, bounded by a count.
`timescale 1ns/1ns
module testbench;
   import msr_pkg::*;
   logic        clk, rst, rd, wr, irq, ack, valid, wide, en, wreq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, message_payload, v;
   logic [3:0]  be, dly;
   logic [63:0] maddr;
   int          n_mismatch = 0, num_checks = 0;
   logic [7:0]  offs [6] = '{8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'hF0, 8'hF4};
   logic [31:0] rst_e [6] = '{32'h0080_0005, 32'h0, 32'h0, 32'h0, 32'h0000_000D, 32'h0};
   logic [31:0] one_e [6] = '{32'h0081_FF05, 32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'h0000_FFFF,
                              32'h0000_FF0D, 32'hFFFF_FFFF};
   msr_regs DUT (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wreq), .IRQ_EVENT_I(irq), .MSG_ACK_I(ack), .MSG_VALID_O(valid),
      .MSG_WIDE_O(wide), .MSG_ADDR_O(maddr), .MSG_DATA_O(message_payload), .MSI_ENABLE_O(en));
   msr_upstream_model u_up (.clk_i(clk), .rst_i(rst), .valid_i(valid), .dly_i(dly), .ack_o(ack));
   task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // One access; read data is taken at the edge where waitrequest is low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int i;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      v = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 20) check("bus_answer", 1, 0);
   endtask
   // Pulse an event; expect one message with the given fields, or none.
   task automatic fire(input logic on, input logic [63:0] ea, input logic ew);
      int i;
      logic hit;
      hit = 1'b0;
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         if (valid === 1'b1) break;
         hit = (i == 7);
      end
      if (!on) check("msg_dropped", hit, 1);
      if (!on) return;
      check("msg_raised", hit, 0);
      check("msg_addr", maddr, ea);
      check("msg_wide", wide, ew);
      check("msg_data", message_payload, 32'h0000_1234);
      for (i = 0; i < 20 && valid !== 1'b0; i++) @(posedge clk);
      check("msg_taken", valid, 0);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // A hang past the expected span counts as a failure.
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      {rst, rd, wr, irq, addr, wdata, be, dly} = {1'b1, 51'h0};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, offs[k], 32'h0, 4'hF);
         check("reset_value", v, rst_e[k]);
      end
      bus(1'b0, 8'hE0, 32'h0, 4'hF);
      check("unmapped", v, 0);
      $display("test reset_values done");
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, offs[k], 32'hFFFF_FFFF, 4'hF);
         bus(1'b0, offs[k], 32'h0, 4'hF);
         check("all_ones", v, one_e[k]);
      end
      check("enable_on", en, 1);
      bus(1'b1, 8'hF4, 32'h0, 4'h1);
      bus(1'b0, 8'hF4, 32'h0, 4'hF);
      check("lane_merge", v, 32'hFFFF_FF00);
      $display("test access_kinds done");
      // Address below routes to the root port; the low two bits must drop.
      bus(1'b1, 8'hD4, 32'h1234_567B, 4'hF);
      bus(1'b1, 8'hD8, 32'h0, 4'hF);
      bus(1'b1, 8'hDC, 32'hABCD_1234, 4'hF);
      fire(1'b1, 64'h0000_0000_1234_5678, 1'b0);
      dly <= 4'h5;
      bus(1'b1, 8'hD8, 32'h0000_0001, 4'hF);
      fire(1'b1, 64'h0000_0001_1234_5678, 1'b1);
      bus(1'b1, 8'hD0, 32'h0, 4'hF);
      check("enable_off", en, 0);
      fire(1'b0, 64'h0, 1'b0);
      $display("test messages done");
      final_report();
   end
endmodule // testbench
